// ===== shared/i2c_ctrl_pkg.sv
// Constants of the two-channel I2C mode control register front end.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.

package i2c_ctrl_pkg;
    // Register indexes; the byte address is four times the index
    localparam logic [11:0] IDX_CH0_TRANSFER_CONFIG = 12'h240;
    localparam logic [11:0] IDX_CH0_BUS_COMMAND = 12'h243;
    localparam logic [11:0] IDX_CH0_ENABLE_CONTROL = 12'h247;
    localparam logic [11:0] IDX_CH1_TRANSFER_CONFIG = 12'h248;
    localparam logic [11:0] IDX_CH1_BUS_COMMAND = 12'h24b;
    localparam logic [11:0] IDX_CH1_ENABLE_CONTROL = 12'h24f;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h250;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h251;

    // Enable register fields
    localparam int EN_BIT = 7;
    // Transfer config fields
    localparam int BC_HI = 7;
    localparam int BC_LO = 5;
    localparam int ACK_BIT = 4;
    localparam int SCK_HI = 2;
    localparam int SCK_LO = 0;
    localparam int MON_BIT = 0;
    // Bus command fields
    localparam int MST_BIT = 7;
    localparam int TRX_BIT = 6;
    localparam int BB_BIT = 5;
    localparam int PIN_BIT = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 2;
    localparam int SWR_HI = 1;
    localparam int SWR_LO = 0;
    // Interrupt status layout
    localparam int IRQ_SWR_LO = 0;
    localparam int IRQ_BUS_LO = 2;
    localparam int IRQ_W = 4;

    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h10;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

    // Encodings
    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_I2C = 2'h2;
    localparam logic [1:0] SWR_ARM = 2'h2;
    localparam logic [1:0] SWR_FIRE = 2'h1;
    localparam logic [2:0] SCK_RESERVED = 3'h7;

    // Divider: half period of the line clock is 2**n + 36 system cycles
    localparam int DIV_BASE = 36;
    localparam int DIV_N_MIN = 4;
    localparam int DIV_N_MAX = 10;
    localparam int DIV_W = 11;

    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SOFT_RESET_NS = 24;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        SWR_IDLE = 2'b00,
        SWR_ARMED = 2'b01,
        SWR_ACTIVE = 2'b11
    } swr_state_t;
endpackage : i2c_ctrl_pkg

// ===== rtl/scl_divider.sv
// Serial line clock divider for one channel.
// Assumes run comes from registers on hclk.
`timescale 1ns/1ps
`default_nettype none

module scl_divider
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic run,
    input wire logic [2:0] sel,
    // Line clock
    output logic scl
);
    logic [i2c_ctrl_pkg::DIV_W-1:0] cnt;
    logic [i2c_ctrl_pkg::DIV_W-1:0] half;
    int n;

    // Reserved code runs at the slowest rate to stay within standard mode
    always_comb
    begin
        n = i2c_ctrl_pkg::DIV_N_MIN + int'(sel);
        if (sel == i2c_ctrl_pkg::SCK_RESERVED)
        begin
            n = i2c_ctrl_pkg::DIV_N_MAX;
        end
        half = i2c_ctrl_pkg::DIV_W'((1 << n) + i2c_ctrl_pkg::DIV_BASE);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= '0;
            scl <= 1'b1;
        end
        else if (!run || cnt >= half - 1'b1)
        begin
            cnt <= '0;
            scl <= run ? !scl : 1'b1;
        end
        else
        begin
            cnt <= cnt + 1'b1;
        end
    end

    a_scl_idle_high: assert property (@(posedge hclk) disable iff (!hresetn) !run |=> scl)
        else $error("line clock not high while stopped");
    a_scl_toggle_point: assert property (@(posedge hclk) disable iff (!hresetn)
        (run && cnt == half - 1'b1) |=> (scl != $past(scl)) && cnt == '0)
        else $error("line clock did not toggle at half period");
endmodule : scl_divider

`default_nettype wire

// ===== rtl/soft_reset_seq.sv
// Software reset sequencer for one channel: 10 then 01 fires a timed reset.
// Assumes write is a one-cycle strobe on hclk carrying the field value.
`timescale 1ns/1ps
`default_nettype none

module soft_reset_seq
#(
    parameter int CYCLES = i2c_ctrl_pkg::SOFT_RESET_CYCLES
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Field write
    input wire logic write,
    input wire logic [1:0] field,
    // Results
    output logic chan_reset,
    output logic monitor,
    output logic done
);
    i2c_ctrl_pkg::swr_state_t state;
    logic [7:0] cnt;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= i2c_ctrl_pkg::SWR_IDLE;
            cnt <= 8'h00;
            chan_reset <= 1'b0;
            monitor <= 1'b1;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state)
                i2c_ctrl_pkg::SWR_IDLE, i2c_ctrl_pkg::SWR_ARMED:
                begin
                    if (write && field == i2c_ctrl_pkg::SWR_ARM)
                    begin
                        state <= i2c_ctrl_pkg::SWR_ARMED;
                    end
                    else if (write && state == i2c_ctrl_pkg::SWR_ARMED && field == i2c_ctrl_pkg::SWR_FIRE)
                    begin
                        state <= i2c_ctrl_pkg::SWR_ACTIVE;
                        cnt <= 8'(CYCLES - 1);
                        chan_reset <= 1'b1;
                        monitor <= 1'b0;
                    end
                    else if (write)
                    begin
                        state <= i2c_ctrl_pkg::SWR_IDLE;
                    end
                end
                i2c_ctrl_pkg::SWR_ACTIVE:
                begin
                    if (cnt == 8'h00)
                    begin
                        state <= i2c_ctrl_pkg::SWR_IDLE;
                        chan_reset <= 1'b0;
                        monitor <= 1'b1;
                        done <= 1'b1;
                    end
                    else
                    begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default:
                begin
                    state <= i2c_ctrl_pkg::SWR_IDLE;
                end
            endcase
        end
    end

    sequence s_fire;
        state == i2c_ctrl_pkg::SWR_ARMED && write && field == i2c_ctrl_pkg::SWR_FIRE;
    endsequence
    sequence s_hold;
        (chan_reset && !monitor) [*6] ##1 (!chan_reset && monitor && done);
    endsequence

    a_fire_reset_length: assert property (@(posedge hclk) disable iff (!hresetn) s_fire |=> s_hold)
        else $error("soft reset not held for its length");
    a_monitor_tracks: assert property (@(posedge hclk) disable iff (!hresetn) monitor == !chan_reset)
        else $error("reset monitor disagrees with reset");
endmodule : soft_reset_seq

`default_nettype wire

// ===== rtl/i2c_mode_control_regs.sv
// Two-channel I2C mode control registers behind an AHB-Lite slave.
// Assumes the protocol engine runs on hclk and feeds status the same clock.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module i2c_mode_control_regs
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [13:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Protocol engine status, one bit per channel
    input wire logic [1:0] controller_state,
    input wire logic [1:0] direction_state,
    input wire logic [1:0] bus_occupied,
    input wire logic [1:0] bus_event,
    input wire logic [1:0] arbitration_lost,
    input wire logic [1:0] address_match,
    input wire logic [1:0] general_call,
    input wire logic [1:0] last_bit,
    // Channel controls
    output logic [1:0] operation_enable,
    output logic [1:0] outputs_enabled,
    output logic [1:0] serial_clock,
    output logic [1:0] controller_select,
    output logic [1:0] direction_select,
    output logic [1:0] start_pulse,
    output logic [1:0] stop_pulse,
    output logic [1:0] soft_reset_out,
    output logic [1:0] bus_irq,
    output logic [3:0] pulse_count0,
    output logic [3:0] pulse_count1,
    output logic [3:0] data_bits0,
    output logic [3:0] data_bits1,
    // Interrupt
    output logic irq
);
    // ==========================================================
    // Helpers
    function automatic logic [3:0] bit_count(input logic [2:0] bc);
        bit_count = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
    endfunction : bit_count

    function automatic logic [3:0] clock_pulses(input logic [2:0] bc, input logic ack);
        clock_pulses = bit_count(bc) + {3'h0, ack};
    endfunction : clock_pulses

    function automatic logic [11:0] chan_index(input int ch, input int kind);
        logic [11:0] base;
        base = (ch == 0) ? i2c_ctrl_pkg::IDX_CH0_TRANSFER_CONFIG : i2c_ctrl_pkg::IDX_CH1_TRANSFER_CONFIG;
        if (kind == 1)
        begin
            base = (ch == 0) ? i2c_ctrl_pkg::IDX_CH0_BUS_COMMAND : i2c_ctrl_pkg::IDX_CH1_BUS_COMMAND;
        end
        else if (kind == 2)
        begin
            base = (ch == 0) ? i2c_ctrl_pkg::IDX_CH0_ENABLE_CONTROL : i2c_ctrl_pkg::IDX_CH1_ENABLE_CONTROL;
        end
        chan_index = base;
    endfunction : chan_index

    // ==========================================================
    // Bus slave
    logic accept;
    logic rd_pend;
    logic wr_q;
    logic [11:0] idx_q;
    logic [1:0] wr_cfg;
    logic [1:0] wr_cmd;
    logic [1:0] wr_en;
    logic wr_status;
    logic wr_mask;
    logic [7:0] read_byte;

    assign accept = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd_pend <= 1'b0;
            idx_q <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            wr_q <= accept && hwrite;
            rd_pend <= accept && !hwrite;
            // Reads take one wait state so the data come out of a register
            hreadyout <= !(accept && !hwrite);
            hresp <= 1'b0;
            if (accept)
            begin
                idx_q <= haddr[13:2];
            end
        end
    end

    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            wr_cfg[c] = wr_q && idx_q == chan_index(c, 0);
            wr_cmd[c] = wr_q && idx_q == chan_index(c, 1);
            wr_en[c] = wr_q && idx_q == chan_index(c, 2);
        end
        wr_status = wr_q && idx_q == i2c_ctrl_pkg::IDX_IRQ_STATUS;
        wr_mask = wr_q && idx_q == i2c_ctrl_pkg::IDX_IRQ_MASK;
    end

    // ==========================================================
    // Channel registers
    logic [7:0] cfg [2];
    logic [7:0] cmd [2];
    logic [1:0] swr_monitor;
    logic [1:0] swr_done;

    // Enable register is untouched by the channel soft reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            operation_enable <= i2c_ctrl_pkg::EN_RESET[1:0];
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (wr_en[c])
                begin
                    operation_enable[c] <= hwdata[i2c_ctrl_pkg::EN_BIT];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg[0] <= i2c_ctrl_pkg::CFG_RESET;
            cfg[1] <= i2c_ctrl_pkg::CFG_RESET;
            cmd[0] <= i2c_ctrl_pkg::CMD_RESET;
            cmd[1] <= i2c_ctrl_pkg::CMD_RESET;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (soft_reset_out[c])
                begin
                    cfg[c] <= i2c_ctrl_pkg::CFG_RESET;
                    cmd[c] <= i2c_ctrl_pkg::CMD_RESET;
                end
                else
                begin
                    if (wr_cfg[c])
                    begin
                        cfg[c] <= hwdata[7:0];
                    end
                    if (wr_cmd[c])
                    begin
                        cmd[c] <= hwdata[7:0];
                    end
                end
            end
        end
    end

    // Pending bus interrupt; a new event wins over a cancel in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_irq <= 2'h0;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (bus_event[c])
                begin
                    bus_irq[c] <= 1'b1;
                end
                else if (soft_reset_out[c] || (wr_cmd[c] && hwdata[i2c_ctrl_pkg::PIN_BIT]))
                begin
                    bus_irq[c] <= 1'b0;
                end
            end
        end
    end

    // Start or stop request on each command write outside a channel soft reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_pulse <= 2'h0;
            stop_pulse <= 2'h0;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                start_pulse[c] <= wr_cmd[c] && !soft_reset_out[c] && hwdata[i2c_ctrl_pkg::BB_BIT];
                stop_pulse[c] <= wr_cmd[c] && !soft_reset_out[c] && !hwdata[i2c_ctrl_pkg::BB_BIT];
            end
        end
    end

    // Decoded controls for the protocol engine
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            outputs_enabled <= 2'h0;
            controller_select <= 2'h0;
            direction_select <= 2'h0;
            pulse_count0 <= 4'h8;
            pulse_count1 <= 4'h8;
            data_bits0 <= 4'h8;
            data_bits1 <= 4'h8;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                outputs_enabled[c] <= operation_enable[c]
                    && cmd[c][i2c_ctrl_pkg::MODE_HI:i2c_ctrl_pkg::MODE_LO] == i2c_ctrl_pkg::MODE_I2C;
                controller_select[c] <= cmd[c][i2c_ctrl_pkg::MST_BIT];
                direction_select[c] <= cmd[c][i2c_ctrl_pkg::TRX_BIT];
            end
            pulse_count0 <= clock_pulses(cfg[0][i2c_ctrl_pkg::BC_HI:i2c_ctrl_pkg::BC_LO],
                cfg[0][i2c_ctrl_pkg::ACK_BIT]);
            pulse_count1 <= clock_pulses(cfg[1][i2c_ctrl_pkg::BC_HI:i2c_ctrl_pkg::BC_LO],
                cfg[1][i2c_ctrl_pkg::ACK_BIT]);
            data_bits0 <= bit_count(cfg[0][i2c_ctrl_pkg::BC_HI:i2c_ctrl_pkg::BC_LO]);
            data_bits1 <= bit_count(cfg[1][i2c_ctrl_pkg::BC_HI:i2c_ctrl_pkg::BC_LO]);
        end
    end

    // ==========================================================
    // Per-channel divider and soft reset
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        scl_divider u_div
        (
            .hclk(hclk),
            .hresetn(hresetn),
            .run(outputs_enabled[g] && controller_select[g]),
            .sel(cfg[g][i2c_ctrl_pkg::SCK_HI:i2c_ctrl_pkg::SCK_LO]),
            .scl(serial_clock[g])
        );
        soft_reset_seq u_swr
        (
            .hclk(hclk),
            .hresetn(hresetn),
            .write(wr_cmd[g]),
            .field(hwdata[i2c_ctrl_pkg::SWR_HI:i2c_ctrl_pkg::SWR_LO]),
            .chan_reset(soft_reset_out[g]),
            .monitor(swr_monitor[g]),
            .done(swr_done[g])
        );
    end

    // ==========================================================
    // Interrupt status and mask
    logic [i2c_ctrl_pkg::IRQ_W-1:0] irq_status;
    logic [i2c_ctrl_pkg::IRQ_W-1:0] irq_mask;
    logic [i2c_ctrl_pkg::IRQ_W-1:0] irq_set;

    assign irq_set = {bus_event, swr_done};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status <= '0;
            irq_mask <= i2c_ctrl_pkg::MASK_RESET;
            irq <= 1'b0;
        end
        else
        begin
            // Set wins over a write-one-to-clear in the same cycle
            irq_status <= irq_set | (irq_status & ~(wr_status ? hwdata[i2c_ctrl_pkg::IRQ_W-1:0] : '0));
            if (wr_mask)
            begin
                irq_mask <= hwdata[i2c_ctrl_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ==========================================================
    // Read data
    always_comb
    begin
        read_byte = 8'h00;
        for (int c = 0; c < 2; c++)
        begin
            if (idx_q == chan_index(c, 0))
            begin
                read_byte = {cfg[c][7:1], swr_monitor[c]};
            end
            else if (idx_q == chan_index(c, 1))
            begin
                read_byte = {controller_state[c], direction_state[c], bus_occupied[c], !bus_irq[c],
                    arbitration_lost[c], address_match[c], general_call[c], last_bit[c]};
            end
            else if (idx_q == chan_index(c, 2))
            begin
                read_byte = {operation_enable[c], 7'h00};
            end
        end
        if (idx_q == i2c_ctrl_pkg::IDX_IRQ_STATUS)
        begin
            read_byte = {4'h0, irq_status};
        end
        else if (idx_q == i2c_ctrl_pkg::IDX_IRQ_MASK)
        begin
            read_byte = {4'h0, irq_mask};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_pend)
        begin
            hrdata <= {24'h000000, read_byte};
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_read_wait_state: assert property ((accept && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    a_cancel_clears_irq: assert property ((wr_cmd[0] && hwdata[4] && !bus_event[0]) |=> !bus_irq[0])
        else $error("cancel did not clear bus interrupt");
    a_event_beats_cancel: assert property (bus_event[1] |=> bus_irq[1])
        else $error("bus event lost");
    a_start_from_write: assert property ((wr_cmd[0] && !soft_reset_out[0] && hwdata[5])
        |=> start_pulse[0] && !stop_pulse[0] ##1 (!start_pulse[0] || $past(wr_cmd[0])))
        else $error("start request not one pulse");
    a_seven_pulses: assert property ((cfg[0][7:5] == 3'h6 && cfg[0][4])
        |=> pulse_count0 == 4'h7 && data_bits0 == 4'h6)
        else $error("six bits with ack must give seven pulses");
    a_port_mode_quiet: assert property ((cmd[0][3:2] == 2'h0) |=> !outputs_enabled[0] ##1 serial_clock[0])
        else $error("port mode left outputs or clock active");
    a_irq_follows_mask: assert property ((irq_status & irq_mask) != '0 |=> irq)
        else $error("unmasked status did not raise irq");
endmodule : i2c_mode_control_regs

`default_nettype wire

// ===== bench/i2c_engine_model.sv
// Model of the protocol engine and bus peers behind the control registers.
// Assumes the bench sets the status levels and requests bus events.
`timescale 1ns/1ps
`default_nettype none

module i2c_engine_model
(
    // Clock
    input wire logic hclk,
    // Requests from the bench
    input wire logic [15:0] st,
    input wire logic kick,
    // Engine status levels and event pulses
    output logic [15:0] lv,
    output logic [1:0] ev = 2'h0
);
    logic kick_d = 1'b0;

    assign lv = st;

    // One-cycle event on both channels for each rising request
    always @(posedge hclk)
    begin
        kick_d <= kick;
        ev <= {2{kick & ~kick_d}};
    end
endmodule : i2c_engine_model
`default_nettype wire

// ===== bench/tb_i2c_mode_control_regs.sv
// Self-checking bench for the I2C mode control registers.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_mode_control_regs;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [13:0] haddr = 14'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] st = 16'h0;
    logic kick = 1'b0;
    logic [31:0] r;
    wire logic hreadyout, irq, rsp;
    wire logic [31:0] hrdata;
    wire logic [15:0] lv;
    wire logic [1:0] ev, oe, oen, scl, cs, ds, sp, tp, sr, bi;
    wire logic [3:0] pc0, db0, pc1, db1;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 94;
    int cyc = 0;

    always #2 hclk = ~hclk;

    i2c_engine_model engine_u (.hclk(hclk), .st(st), .kick(kick), .lv(lv), .ev(ev));

    i2c_mode_control_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(rsp), .controller_state(lv[1:0]),
        .direction_state(lv[3:2]), .bus_occupied(lv[5:4]), .bus_event(ev), .arbitration_lost(lv[7:6]),
        .address_match(lv[9:8]), .general_call(lv[11:10]), .last_bit(lv[13:12]), .operation_enable(oe),
        .outputs_enabled(oen), .serial_clock(scl), .controller_select(cs), .direction_select(ds),
        .start_pulse(tp), .stop_pulse(sp), .soft_reset_out(sr), .bus_irq(bi), .pulse_count0(pc0),
        .pulse_count1(pc1), .data_bits0(db0), .data_bits1(db1), .irq(irq));

    // =========================================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Single word transfer, whole byte written, never read-modify-write
    task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
        @(posedge hclk);
        haddr <= {i, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : tick

    function automatic logic [3:0] bits_of(input logic [2:0] c);
        return (c == 3'h0) ? 4'h8 : {1'b0, c};
    endfunction : bits_of

    task automatic half(input int s);
        int n = 0;
        repeat (2) @(posedge scl[0]);
        do
        begin
            @(posedge hclk);
            #1 n++;
        end
        while (scl[0] !== 1'b0);
        chk("half_period", n, (1 << (4 + s)) + 36);
    endtask : half

    task automatic pulses(input logic [7:0] d, input logic [1:0] e);
        logic [31:0] s = 0;
        logic [31:0] t = 0;
        bus(1'b1, 12'h243, d);
        repeat (3)
        begin
            #1 s += tp[0];
            t += sp[0];
            @(posedge hclk);
        end
        chk("start", s, e[1]);
        chk("stop", t, e[0]);
    endtask : pulses

    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            finish_test();
        end
    end

    // =========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        bus(1'b0, 12'h240, 8'h00);
        chk("cfg_reset", r, 32'h1);
        chk("hresp", rsp, 1'b0);
        bus(1'b0, 12'h243, 8'h00);
        chk("status_reset", r, 32'h10);
        bus(1'b0, 12'h247, 8'h00);
        chk("enable_reset", r, 32'h0);
        bus(1'b0, 12'h241, 8'h00);
        chk("unmapped", r, 32'h0);
        // Enable goes first
        bus(1'b1, 12'h247, 8'hff);
        bus(1'b0, 12'h247, 8'h00);
        chk("enable", r, 32'h80);
        chk("enable_port", oe[0], 1'b1);
        for (int k = 0; k < 16; k++)
        begin
            bus(1'b1, 12'h240, {k[2:0], k[3], 4'h0});
            tick(1);
            chk("data_bits", db0, bits_of(k[2:0]));
            chk("pulse_count", pc0, bits_of(k[2:0]) + k[3]);
        end
        // Channel 1, enable first
        bus(1'b1, 12'h24f, 8'h80);
        bus(1'b1, 12'h248, 8'hd0);
        tick(1);
        chk("enable1", oe[1], 1'b1);
        chk("pulse_count1", pc1, 32'h7);
        chk("data_bits1", db1, 32'h6);
        chk("outputs_off1", oen[1], 1'b0);
        chk("clock_idle1", scl[1], 1'b1);
        repeat (4)
        begin
            @(posedge hclk) st <= 16'($random(seed));
            tick(1);
            bus(1'b0, 12'h243, 8'h00);
            chk("status", r, {st[0], st[2], st[4], 1'b1, st[6], st[8], st[10], st[12]});
        end
        bus(1'b1, 12'h240, 8'h00);
        bus(1'b1, 12'h243, 8'hc8);
        tick(2);
        chk("outputs_on", oen[0], 1'b1);
        chk("controller", cs[0], 1'b1);
        chk("direction", ds[0], 1'b1);
        half(0);
        bus(1'b1, 12'h240, 8'h06);
        half(6);
        pulses(8'ha8, 2'b10);
        pulses(8'h88, 2'b01);
        kick <= 1'b1;
        tick(3);
        @(posedge hclk) kick <= 1'b0;
        chk("bus_irq_set", bi[0], 1'b1);
        chk("bus_irq_set1", bi[1], 1'b1);
        bus(1'b0, 12'h250, 8'h00);
        chk("irq_status", r[2], 1'b1);
        chk("irq_masked", irq, 1'b0);
        bus(1'b1, 12'h251, 8'h04);
        tick(1);
        chk("irq_on", irq, 1'b1);
        bus(1'b1, 12'h243, 8'h88);
        tick(1);
        chk("cancel_zero", bi[0], 1'b1);
        bus(1'b1, 12'h243, 8'h98);
        tick(1);
        chk("cancel_one", bi[0], 1'b0);
        bus(1'b1, 12'h250, 8'h04);
        tick(2);
        chk("irq_cleared", irq, 1'b0);
        bus(1'b1, 12'h243, 8'h8a);
        bus(1'b1, 12'h243, 8'h89);
        bus(1'b0, 12'h240, 8'h00);
        chk("monitor_busy", r[0], 1'b0);
        chk("soft_reset_on", sr[0], 1'b1);
        tick(8);
        chk("soft_reset_off", sr[0], 1'b0);
        bus(1'b0, 12'h240, 8'h00);
        chk("monitor_idle", r, 32'h1);
        bus(1'b0, 12'h250, 8'h00);
        chk("reset_done", r[0], 1'b1);
        finish_test();
    end
endmodule : tb_i2c_mode_control_regs
`default_nettype wire
